// *** include/config_pin_pkg.sv ***
// Constants, register map and timing for the configuration pin control block
`default_nettype none
package config_pin_pkg;
  // Clock rate and derived cycle counts
  localparam int CLK_FREQ_KHZ   = 10000;
  localparam int CLEAR_TIME_NS  = 10000;
  localparam int BUSY_TIME_NS   = 400;
  localparam int STROBE_TIME_NS = 300;
  localparam int CLEAR_CYCLES   = (CLEAR_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int BUSY_CYCLES    = (BUSY_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int STROBE_CYCLES  = (STROBE_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;
  localparam int TIMER_W        = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LENGTH = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0C;

  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SCAN_BIT  = 1;
  localparam int CTRL_MODE_LSB  = 2;
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [15:0] LENGTH_RESET = 16'h0010;

  // Status fields
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_READY_BIT  = 1;
  localparam int STAT_PHASE_LSB  = 2;
  localparam int STAT_COUNT_LSB  = 16;

  // Configuration modes
  localparam logic [1:0] MODE_ASYNC_PERIPH = 2'h0;
  localparam logic [1:0] MODE_SLAVE_PAR    = 2'h1;
  localparam logic [1:0] MODE_PROC_PORT    = 2'h2;
  localparam logic [1:0] MODE_MASTER_PAR   = 2'h3;

  typedef enum logic [1:0] {PH_CLEAR, PH_WAIT, PH_LOAD, PH_DONE} phase_type;
endpackage
`default_nettype wire

// *** logic/config_pin_control.sv ***
// Configuration-time control pins with a Wishbone register slave
`default_nettype none
module config_pin_control
  import config_pin_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Host pins
  input  wire logic        select_active_low_i,
  input  wire logic        select_active_high_i,
  input  wire logic        write_n_i,
  input  wire logic        read_n_i,
  input  wire logic [7:0]  data_i,
  output logic             data_bit_seven_o,
  output logic             data_bit_seven_oe_o,
  output logic             handshake_o,
  output logic             handshake_oe_o,
  // Configuration status pins
  output logic             config_pending_high_o,
  output logic             config_pending_high_oe_o,
  output logic             config_pending_low_n_o,
  output logic             config_pending_low_n_oe_o,
  input  wire logic        wait_clear_n_i,
  output logic             wait_clear_n_o,
  output logic             wait_clear_n_oe_o,
  // Core side
  output logic             scan_enable_o,
  output logic [7:0]       cfg_byte_o,
  output logic             cfg_byte_valid_o
);

  localparam int SYNC_W = 13;

  function automatic logic is_selected(input logic sel_lo, input logic sel_hi);
    return !sel_lo && sel_hi;
  endfunction

  logic [SYNC_W-1:0]  sync1_q;
  logic [SYNC_W-1:0]  sync2_q;
  logic               write_prev_q;
  phase_type          phase_q;
  logic [3:0]         ctrl_q;
  logic [15:0]        length_q;
  logic [15:0]        count_q;
  logic [TIMER_W-1:0] busy_q;
  logic [TIMER_W-1:0] strobe_q;
  logic [7:0]         byte_q;
  logic               byte_valid_q;
  logic               ack_q;
  logic [31:0]        rdata_q;

  logic       pin_sel_lo;
  logic       pin_sel_hi;
  logic       pin_write_n;
  logic       pin_read_n;
  logic       pin_wait_n;
  logic [7:0] pin_data;
  logic [1:0] mode;
  logic       master;
  logic       selected;
  logic       ready;
  logic       byte_take;
  logic       strobe_start;
  logic       loading;
  logic       wb_req;

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= {SYNC_W{1'b1}};
      sync2_q <= {SYNC_W{1'b1}};
    end
    else
    begin
      sync1_q <= {select_active_low_i, select_active_high_i, write_n_i, read_n_i,
                  wait_clear_n_i, data_i};
      sync2_q <= sync1_q;
    end
  end

  assign pin_sel_lo  = sync2_q[12];
  assign pin_sel_hi  = sync2_q[11];
  assign pin_write_n = sync2_q[10];
  assign pin_read_n  = sync2_q[9];
  assign pin_wait_n  = sync2_q[8];
  assign pin_data    = sync2_q[7:0];

  assign mode     = ctrl_q[CTRL_MODE_LSB +: 2];
  assign master   = (mode == MODE_MASTER_PAR);
  assign loading  = (phase_q == PH_LOAD);
  assign selected = is_selected(pin_sel_lo, pin_sel_hi);
  assign ready    = loading && !master && (busy_q == '0);

  // A byte is taken on the write falling edge, or at the end of a read strobe
  assign byte_take = loading && (master ? (strobe_q == TIMER_W'(1)) :
                     (selected && write_prev_q && !pin_write_n && ready));
  assign strobe_start = loading && master && (strobe_q == '0) && (busy_q == '0) &&
                        (count_q < length_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      write_prev_q <= 1'b1;
    else
      write_prev_q <= pin_write_n;
  end

  // Phase sequencing; busy timer doubles as the clearing timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q <= PH_CLEAR;
      busy_q  <= TIMER_W'(CLEAR_CYCLES);
    end
    else
    begin
      case (phase_q)
        PH_CLEAR:
        begin
          if (busy_q == '0)
            phase_q <= PH_WAIT;
          else
            busy_q <= busy_q - TIMER_W'(1);
        end
        PH_WAIT:
        begin
          if (pin_wait_n && ctrl_q[CTRL_START_BIT])
            phase_q <= PH_LOAD;
        end
        PH_LOAD:
        begin
          if (byte_take)
            busy_q <= TIMER_W'(BUSY_CYCLES);
          else if (busy_q != '0)
            busy_q <= busy_q - TIMER_W'(1);
          else if (strobe_q == '0 && count_q >= length_q)
            phase_q <= PH_DONE;
        end
        PH_DONE:
          busy_q <= '0;
        default:
          phase_q <= PH_CLEAR;
      endcase
    end
  end

  // Read strobe toward memory, active low while the counter runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      strobe_q <= '0;
    else if (strobe_start)
      strobe_q <= TIMER_W'(STROBE_CYCLES);
    else if (strobe_q != '0)
      strobe_q <= strobe_q - TIMER_W'(1);
  end

  // Byte capture
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q      <= '0;
      byte_q       <= 8'h00;
      byte_valid_q <= 1'b0;
    end
    else
    begin
      byte_valid_q <= byte_take;
      if (byte_take)
      begin
        count_q <= count_q + 16'h0001;
        byte_q  <= pin_data;
      end
    end
  end

  // Wishbone slave, one wait state
  assign wb_req = wb_cyc_i && wb_stb_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= wb_req && !ack_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q   <= CTRL_RESET;
      length_q <= LENGTH_RESET;
    end
    else if (wb_req && wb_we_i && ack_q)
    begin
      if (wb_adr_i == ADDR_CTRL && wb_sel_i[0])
        ctrl_q <= wb_dat_i[3:0];
      if (wb_adr_i == ADDR_LENGTH && wb_sel_i[0])
        length_q[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == ADDR_LENGTH && wb_sel_i[1])
        length_q[15:8] <= wb_dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= 32'h00000000;
    else if (wb_req && !ack_q)
    begin
      case (wb_adr_i)
        ADDR_CTRL:   rdata_q <= {28'h0000000, ctrl_q};
        ADDR_LENGTH: rdata_q <= {16'h0000, length_q};
        ADDR_STATUS: rdata_q <= {count_q, 12'h000, 2'(phase_q), ready,
                                 phase_q == PH_DONE};
        ADDR_DATA:   rdata_q <= {24'h000000, byte_q};
        default:     rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Pin drive; every configuration pin is released once done
  assign handshake_o               = master ? (strobe_q == '0) : ready;
  assign handshake_oe_o            = loading;
  assign data_bit_seven_o          = ready;
  assign data_bit_seven_oe_o       = loading && mode == MODE_ASYNC_PERIPH && selected &&
                                     !pin_read_n;
  assign config_pending_high_o     = (phase_q != PH_DONE);
  assign config_pending_high_oe_o  = (phase_q != PH_DONE);
  assign config_pending_low_n_o    = (phase_q == PH_DONE);
  assign config_pending_low_n_oe_o = (phase_q != PH_DONE);
  assign wait_clear_n_o            = 1'b0;
  assign wait_clear_n_oe_o         = (phase_q == PH_CLEAR);
  // Scan stays usable during configuration so the test port can load too
  assign scan_enable_o             = (phase_q != PH_DONE) || ctrl_q[CTRL_SCAN_BIT];
  assign cfg_byte_o                = byte_q;
  assign cfg_byte_valid_o          = byte_valid_q;

  sequence s_busy;
    !handshake_o [*4];
  endsequence
  sequence s_strobe_low;
    !handshake_o [*3] ##1 handshake_o;
  endsequence

  property p_clear_drives;
    @(posedge clk_i) disable iff (rst_i)
    phase_q == PH_CLEAR |-> wait_clear_n_oe_o && !wait_clear_n_o && !handshake_oe_o;
  endproperty
  a_clear_drives: assert property (p_clear_drives) else $error("wait pin not low in clear");

  property p_wait_hold;
    @(posedge clk_i) disable iff (rst_i)
    phase_q == PH_WAIT && !pin_wait_n |=> phase_q == PH_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait with pin low");

  property p_pending_high;
    @(posedge clk_i) disable iff (rst_i)
    phase_q != PH_DONE |-> config_pending_high_o && config_pending_high_oe_o;
  endproperty
  a_pending_high: assert property (p_pending_high) else $error("pending high wrong");

  property p_pending_low;
    @(posedge clk_i) disable iff (rst_i)
    $rose(phase_q == PH_DONE) |-> $past(!config_pending_low_n_o && config_pending_low_n_oe_o);
  endproperty
  a_pending_low: assert property (p_pending_low) else $error("pending low wrong");

  property p_release;
    @(posedge clk_i) disable iff (rst_i)
    phase_q == PH_DONE |-> !(handshake_oe_o || config_pending_high_oe_o ||
                             config_pending_low_n_oe_o || wait_clear_n_oe_o);
  endproperty
  a_release: assert property (p_release) else $error("pin not released");

  property p_scan;
    @(posedge clk_i) disable iff (rst_i)
    phase_q == PH_DONE && !ctrl_q[CTRL_SCAN_BIT] |-> !scan_enable_o;
  endproperty
  a_scan: assert property (p_scan) else $error("scan not inhibited");

  property p_busy;
    @(posedge clk_i) disable iff (rst_i)
    byte_take && !master |=> s_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during busy time");

  property p_bit_seven;
    @(posedge clk_i) disable iff (rst_i)
    loading && mode == MODE_ASYNC_PERIPH && selected && !pin_read_n |->
      data_bit_seven_oe_o && data_bit_seven_o == handshake_o;
  endproperty
  a_bit_seven: assert property (p_bit_seven) else $error("bit seven status wrong");

  property p_strobe;
    @(posedge clk_i) disable iff (rst_i)
    strobe_start |=> s_strobe_low;
  endproperty
  a_strobe: assert property (p_strobe) else $error("read strobe width wrong");

  property p_select;
    @(posedge clk_i) disable iff (rst_i)
    !master && !selected |=> $stable(count_q);
  endproperty
  a_select: assert property (p_select) else $error("byte taken unselected");

endmodule
`default_nettype wire

// *** verification/config_pin_control_tb.sv ***
// Self-checking bench for the configuration pin control block
`default_nettype none
module config_pin_control_tb;
  import config_pin_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, cyc, stb, we, ack, sel_hi, hold, master, wr_n, rd_n;
  logic        d7, d7_oe, hs, hs_oe, ph, ph_oe, pl, pl_oe, wc_o, wc_oe, wc_i, scan, cfg_v;
  logic [3:0]  sel;
  logic [7:0]  adr, data, cfg_b, b;
  logic [31:0] wdat, rdat;
  logic [31:0] rd_exp[$], rd_msk[$], byte_q[$];
  int          failures = 0, n_compared = 0, seed = 45, cyc_n = 0, n;
  // Pull-up on the open-drain wait pin
  assign wc_i = (wc_oe ? wc_o : 1'b1) & ~hold;
  config_pin_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .select_active_low_i(1'b0), .select_active_high_i(sel_hi),
    .write_n_i(wr_n), .read_n_i(rd_n), .data_i(data), .data_bit_seven_o(d7),
    .data_bit_seven_oe_o(d7_oe), .handshake_o(hs), .handshake_oe_o(hs_oe),
    .config_pending_high_o(ph), .config_pending_high_oe_o(ph_oe),
    .config_pending_low_n_o(pl), .config_pending_low_n_oe_o(pl_oe), .wait_clear_n_i(wc_i),
    .wait_clear_n_o(wc_o), .wait_clear_n_oe_o(wc_oe), .scan_enable_o(scan),
    .cfg_byte_o(cfg_b), .cfg_byte_valid_o(cfg_v));
  host_model host_u (.clk_i(clk_i), .master_i(master), .handshake_i(hs),
    .handshake_oe_i(hs_oe), .data_o(data), .write_n_o(wr_n), .read_n_o(rd_n));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task chk_w(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_b(input logic g, input logic e);
    chk_w({31'h0, g}, {31'h0, e});
  endtask
  task test_done;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_exp.push_back(e);
    rd_msk.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      failures++;
      test_done();
    end
    if (ack === 1'b1 && we === 1'b0 && rd_exp.size() > 0)
      chk_w(rdat & rd_msk.pop_front(), rd_exp.pop_front());
    if (cfg_v === 1'b1)
      chk_w({24'h0, cfg_b}, byte_q.size() > 0 ? byte_q.pop_front() : 32'hDEAD);
  end
  initial
  begin
    {cyc, stb, we, adr, wdat} = '0;
    sel_hi = 1'b1;
    sel = 4'hF;
    for (int r = 0; r < 2; r++)
    begin
      master <= r[0];
      rst_i  <= 1'b1;
      hold   <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 chk_b(ph, 1'b1);
      chk_b(pl, 1'b0);
      chk_b(wc_oe, 1'b1);
      chk_b(wc_o, 1'b0);
      @(posedge clk_i);
      rd(ADDR_LENGTH, {16'h0, LENGTH_RESET}, 32'hFFFFFFFF);
      wb(1'b1, ADDR_LENGTH, 32'h3);
      wb(1'b1, ADDR_CTRL, {28'h0, r[0] ? MODE_MASTER_PAR : MODE_ASYNC_PERIPH, r[0], 1'b1});
      repeat (CLEAR_CYCLES + 10) @(posedge clk_i);
      #1 chk_b(wc_oe, 1'b0);
      chk_b(ph, 1'b1);
      @(posedge clk_i);
      rd(ADDR_STATUS, {28'h0, PH_WAIT, 2'b00}, 32'hC);
      rd(8'h10, 32'h0, 32'hFFFFFFFF);
      hold <= 1'b0;
      @(posedge clk_i);
      if (r == 0)
      begin
        host_u.set_read(1'b0);
        repeat (6) @(posedge clk_i);
        #1 chk_b(d7_oe, 1'b1);
        chk_b(d7, 1'b1);
        @(posedge clk_i);
        host_u.set_read(1'b1);
        for (int i = 0; i < 3; i++)
        begin
          b = 8'($random(seed));
          if (i == 1)
          begin
            sel_hi <= 1'b0;
            host_u.write_byte(~b);
            #1 chk_b(hs, 1'b1);
            repeat (5) @(posedge clk_i);
            sel_hi <= 1'b1;
          end
          byte_q.push_back({24'h0, b});
          host_u.write_byte(b);
          #1 chk_b(hs, 1'b0);
          @(posedge clk_i);
        end
      end
      else
        for (int i = 0; i < 3; i++) byte_q.push_back(32'hA0 + i);
      n = 0;
      while (ph_oe !== 1'b0 && n < 500)
      begin
        @(posedge clk_i);
        n++;
      end
      #1 chk_b(hs_oe, 1'b0);
      chk_b(pl_oe, 1'b0);
      chk_b(wc_oe, 1'b0);
      chk_b(scan, r[0]);
      @(posedge clk_i);
      rd(ADDR_STATUS, {16'h3, 12'h0, PH_DONE, 2'b01}, 32'hFFFF000D);
      chk_w(byte_q.size(), 32'h0);
    end
    test_done();
  end
endmodule
`default_nettype wire

// *** verification/host_model.sv ***
// Behavioural configuration host and parallel memory model
`default_nettype none
module host_model
  import config_pin_pkg::*;
(
  // Clock and mode
  input  wire logic       clk_i,
  input  wire logic       master_i,
  // Device pins
  input  wire logic       handshake_i,
  input  wire logic       handshake_oe_i,
  output logic      [7:0] data_o,
  output logic            write_n_o,
  output logic            read_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] host_q = 8'h00;
  logic [7:0] mem_q  = 8'hA0;
  logic       hs_q   = 1'b1;
  // Test mode select parked high for the whole run; no test port here
  logic       test_mode_sel_q = 1'b1;
  initial
  begin
    write_n_o = 1'b1;
    read_n_o  = 1'b1;
  end
  // Idle memory shows the inverse so a stale byte cannot pass
  assign data_o = master_i ? (handshake_i ? ~mem_q : mem_q) : host_q;
  always @(posedge clk_i)
  begin
    hs_q <= handshake_i | ~handshake_oe_i;
    if (master_i && handshake_oe_i && handshake_i && !hs_q)
      mem_q <= mem_q + 8'h01;
  end
  task write_byte(input logic [7:0] b);
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while ((handshake_oe_i !== 1'b1 || handshake_i !== 1'b1) && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    host_q    <= b;
    write_n_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    write_n_o <= 1'b1;
    host_q    <= ~b;
  endtask
  task set_read(input logic v);
    read_n_o <= v;
  endtask
endmodule
`default_nettype wire
